/* core/bcd_ctrl.sv */
// bridge control register with parity, system error and positive decode logic
`timescale 1ns/1ps
module bcd_ctrl (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // configuration access, dword indexed, byte enables active low
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [5:0]  i_cfg_dw_addr,
  input  wire logic [3:0]  i_cfg_be_n,
  input  wire logic [31:0] i_cfg_wdata,
  output logic [31:0]      o_cfg_rdata,
  output logic             o_cfg_rvalid,
  // command register and I/O window from the rest of configuration space
  input  wire logic        i_io_space_en,
  input  wire logic        i_mem_space_en,
  input  wire logic        i_serr_drv_en,
  input  wire logic [31:0] i_io_base,
  input  wire logic [31:0] i_io_limit,
  // secondary error events
  input  wire logic        i_s_data_perr,
  input  wire logic        i_s_master,
  input  wire logic        i_s_addr_perr,
  input  wire logic        i_s_serr_l,
  // error pins and status flag strobe
  output logic             o_s_perr_l_o,
  output logic             o_s_perr_oe_n,
  output logic             o_p_serr_l_o,
  output logic             o_p_serr_oe_n,
  output logic             o_s_dpr_set,
  // primary bus decode request and claim
  input  wire logic        i_p_valid,
  input  wire logic        i_p_is_io,
  input  wire logic [31:0] i_p_addr,
  output logic             o_p_claim,
  // secondary bus decode request and claim
  input  wire logic        i_s_valid,
  input  wire logic        i_s_is_io,
  input  wire logic [31:0] i_s_addr,
  output logic             o_s_claim,
  // control bits for the rest of the bridge
  output logic [15:0]      o_bridge_control
);
  // ****************************************
  // register
  // ****************************************
  logic [15:0] bridge_control_r;
  logic [15:0] bridge_control_nxt;
  logic [31:0] rdata_r;
  logic        rvalid_r;

  wire hit      = (i_cfg_dw_addr == bcd_pkg::BRIDGE_CONTROL_DW);
  wire wr_lane  = i_cfg_wr & hit & ~i_cfg_be_n[bcd_pkg::BRIDGE_CONTROL_LANE];
  wire [15:0] impl_mask = {{(16 - bcd_pkg::BC_IMPL_BITS){1'b0}},
                           {bcd_pkg::BC_IMPL_BITS{1'b1}}};
  // only the low four bits of the register are implemented here; the rest reads zero
  assign bridge_control_nxt = wr_lane ? {8'h00, (i_cfg_wdata[23:16] & impl_mask[7:0])} :
                              {8'h00, bridge_control_r[7:0]};
  wire [31:0] rd_word = hit ? {bridge_control_r, 16'h0000} : 32'h0000_0000;

  wire perr_resp = bridge_control_r[bcd_pkg::BC_PERR_RESP_BIT];
  wire serr_fwd  = bridge_control_r[bcd_pkg::BC_SERR_FWD_BIT];
  wire isa_en    = bridge_control_r[bcd_pkg::BC_ISA_EN_BIT];
  wire vga_en    = bridge_control_r[bcd_pkg::BC_VGA_EN_BIT];

  // ****************************************
  // error reporting
  // ****************************************
  logic s_serr_level;
  bcd_pin_sync u_serr_sync (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_pin   (i_s_serr_l),
    .o_level (s_serr_level)
  );

  wire perr_drive   = i_s_data_perr & perr_resp;
  wire dpr_set      = perr_drive & i_s_master;
  wire serr_addr    = i_s_addr_perr & perr_resp;
  wire serr_forward = ~s_serr_level & serr_fwd;
  // the command register's driver enable gates every primary SERR source
  wire serr_drive   = i_serr_drv_en & (serr_addr | serr_forward);

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic vga_io_hit(input logic [31:0] a);
    vga_io_hit = (a[31:16] == bcd_pkg::ISA_HIGH_ZERO) &&
                 (((a[9:0] >= bcd_pkg::VGA_IO_A_LO) && (a[9:0] <= bcd_pkg::VGA_IO_A_HI)) ||
                  ((a[9:0] >= bcd_pkg::VGA_IO_B_LO) && (a[9:0] <= bcd_pkg::VGA_IO_B_HI)));
  endfunction : vga_io_hit

  function automatic logic isa_alias(input logic [31:0] a);
    isa_alias = (a[31:16] == bcd_pkg::ISA_HIGH_ZERO) && (a[9:8] != bcd_pkg::ISA_ALIAS_LOW);
  endfunction : isa_alias

  wire vga_ok     = vga_en & i_io_space_en & i_mem_space_en;
  wire p_in_range = i_io_space_en & (i_p_addr >= i_io_base) & (i_p_addr <= i_io_limit);
  wire s_in_range = i_io_space_en & (i_s_addr >= i_io_base) & (i_s_addr <= i_io_limit);
  wire p_vga_mem  = (i_p_addr >= bcd_pkg::VGA_MEM_LO) & (i_p_addr <= bcd_pkg::VGA_MEM_HI);
  wire s_vga_mem  = (i_s_addr >= bcd_pkg::VGA_MEM_LO) & (i_s_addr <= bcd_pkg::VGA_MEM_HI);
  wire p_vga_io   = vga_io_hit(i_p_addr);
  wire s_vga_io   = vga_io_hit(i_s_addr);

  // ISA mode drops in-range aliases; VGA I/O with VGA off goes only this way
  wire p_io_range = p_in_range & ~(isa_en & isa_alias(i_p_addr));
  wire p_io_claim = p_io_range | (vga_ok & p_vga_io);
  wire p_mem_claim = vga_ok & p_vga_mem;
  wire p_claim    = i_p_valid & (i_p_is_io ? p_io_claim : p_mem_claim);

  // upstream: outside the window, or an ISA alias inside it
  wire s_io_up    = ~s_in_range | (isa_en & isa_alias(i_s_addr));
  wire s_vga_hit  = vga_ok & (i_s_is_io ? s_vga_io : s_vga_mem);
  // other memory windows are decided elsewhere; only the VGA hole is cut here
  wire s_claim    = i_s_valid & ~s_vga_hit & (~i_s_is_io | s_io_up);

  // ****************************************
  // flops
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bridge_control_r <= bcd_pkg::BRIDGE_CONTROL_RST;
      rdata_r          <= 32'h0000_0000;
      rvalid_r         <= 1'b0;
    end else begin
      bridge_control_r <= {8'h00, bridge_control_nxt[7:0]};
      rdata_r          <= i_cfg_rd ? rd_word : 32'h0000_0000;
      rvalid_r         <= i_cfg_rd;
    end
  end

  logic s_perr_r;
  logic p_serr_r;
  logic dpr_r;
  logic p_claim_r;
  logic s_claim_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s_perr_r  <= 1'b0;
      p_serr_r  <= 1'b0;
      dpr_r     <= 1'b0;
      p_claim_r <= 1'b0;
      s_claim_r <= 1'b0;
    end else begin
      s_perr_r  <= perr_drive;
      p_serr_r  <= serr_drive;
      dpr_r     <= dpr_set;
      p_claim_r <= p_claim;
      s_claim_r <= s_claim;
    end
  end

  // open-drain style: output data is always low, enable low means driving
  assign o_s_perr_l_o     = 1'b0;
  assign o_s_perr_oe_n    = ~s_perr_r;
  assign o_p_serr_l_o     = 1'b0;
  assign o_p_serr_oe_n    = ~p_serr_r;
  assign o_s_dpr_set      = dpr_r;
  assign o_p_claim        = p_claim_r;
  assign o_s_claim        = s_claim_r;
  assign o_cfg_rdata      = rdata_r;
  assign o_cfg_rvalid     = rvalid_r;
  assign o_bridge_control = bridge_control_r;
endmodule : bcd_ctrl

/* core/bcd_pkg.sv */
// constants for the bridge control decode and error forwarding block
package bcd_pkg;
  // ****************************************
  // configuration space location
  // ****************************************
  localparam logic [7:0]  BRIDGE_CONTROL_OFS  = 8'h3E;
  localparam logic [5:0]  BRIDGE_CONTROL_DW   = 6'h0F;
  localparam int          BRIDGE_CONTROL_W    = 16;
  localparam logic [15:0] BRIDGE_CONTROL_RST  = 16'h0000;
  localparam int          BRIDGE_CONTROL_LANE = 2;
  // ****************************************
  // field positions inside the 16-bit register (dword bit minus 16)
  // ****************************************
  localparam int BC_PERR_RESP_BIT = 0;
  localparam int BC_SERR_FWD_BIT  = 1;
  localparam int BC_ISA_EN_BIT    = 2;
  localparam int BC_VGA_EN_BIT    = 3;
  localparam int BC_IMPL_BITS     = 4;
  // ****************************************
  // address windows
  // ****************************************
  localparam logic [15:0] ISA_HIGH_ZERO = 16'h0000;
  localparam logic [1:0]  ISA_ALIAS_LOW = 2'h0;
  localparam logic [9:0]  VGA_IO_A_LO   = 10'h3B0;
  localparam logic [9:0]  VGA_IO_A_HI   = 10'h3BB;
  localparam logic [9:0]  VGA_IO_B_LO   = 10'h3C0;
  localparam logic [9:0]  VGA_IO_B_HI   = 10'h3DF;
  localparam logic [31:0] VGA_MEM_LO    = 32'h000A_0000;
  localparam logic [31:0] VGA_MEM_HI    = 32'h000B_FFFF;
  // ****************************************
  // synchroniser
  // ****************************************
  localparam int         SYNC_STAGES = 3;
  localparam logic       PIN_IDLE    = 1'b1;
endpackage : bcd_pkg

/* core/bcd_pin_sync.sv */
// three-stage synchroniser that reports a level once stages one and two agree
`timescale 1ns/1ps
module bcd_pin_sync (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // pin and filtered level
  input  wire logic i_pin,
  output logic      o_level
);
  logic [bcd_pkg::SYNC_STAGES-1:0] stage_r;
  logic                            level_r;
  wire                             agree = (stage_r[1] == stage_r[2]);

  // stage zero is only read by stage one, never by the compare
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      stage_r <= {bcd_pkg::SYNC_STAGES{bcd_pkg::PIN_IDLE}};
      level_r <= bcd_pkg::PIN_IDLE;
    end else begin
      stage_r <= {stage_r[1:0], i_pin};
      if (agree) begin
        level_r <= stage_r[2];
      end
    end
  end

  assign o_level = level_r;
endmodule : bcd_pin_sync

/* bench/bcd_agent.sv */
// secondary bus agent model driving the system error pin
`timescale 1ns/1ps
module bcd_agent (
  // command from the bench
  input  wire logic i_assert,
  // pin with pull-up, seen by the bridge
  output logic      o_serr_l
);
  // a released pin returns to the pull-up level, never a stale low
  assign o_serr_l = i_assert ? 1'b0 : 1'b1;
endmodule : bcd_agent

/* bench/bcd_ctrl_assertions.sv */
// port assertions for the bridge control block
`timescale 1ns/1ps
module bcd_ctrl_chk (
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rst,
  // events and decode inputs
  input wire logic        i_s_data_perr,
  input wire logic        i_s_master,
  input wire logic        i_s_addr_perr,
  input wire logic        i_s_serr_l,
  input wire logic        i_serr_drv_en,
  input wire logic        i_io_space_en,
  input wire logic        i_mem_space_en,
  input wire logic        i_p_valid,
  input wire logic        i_p_is_io,
  input wire logic [31:0] i_p_addr,
  // outputs
  input wire logic        o_s_perr_oe_n,
  input wire logic        o_p_serr_oe_n,
  input wire logic        o_s_dpr_set,
  input wire logic        o_p_claim,
  input wire logic [15:0] o_bridge_control
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire logic [3:0] bc  = o_bridge_control[3:0];
  wire logic [9:0] a10 = i_p_addr[9:0];
  wire logic vok  = bc[3] & i_io_space_en & i_mem_space_en;
  wire logic vmem = vok & !i_p_is_io & (i_p_addr inside {[32'h000A_0000:32'h000B_FFFF]});
  wire logic vio  = vok & i_p_is_io & (i_p_addr[31:16] == 16'h0000)
    & (a10 inside {[10'h3B0:10'h3BB], [10'h3C0:10'h3DF]});
  a_perr_quiet: assert property (!bc[0] |=> o_s_perr_oe_n && !o_s_dpr_set)
    else $error("parity reported while response off");
  a_perr_drive: assert property (i_s_data_perr && bc[0] |=>
    !o_s_perr_oe_n && o_s_dpr_set == $past(i_s_master)) else $error("parity not driven");
  a_apar_quiet: assert property (i_s_addr_perr && bc[1:0] == 2'h0 |=> o_p_serr_oe_n)
    else $error("address parity reported while off");
  a_apar_serr: assert property (i_s_addr_perr && bc[0] && i_serr_drv_en |=>
    !o_p_serr_oe_n) else $error("address parity not reported");
  a_fwd_off: assert property (bc[1:0] == 2'h0 |=> o_p_serr_oe_n)
    else $error("system error driven while disabled");
  a_fwd_on: assert property ((!i_s_serr_l && bc[1] && i_serr_drv_en) [*7] |->
    !o_p_serr_oe_n) else $error("system error not forwarded");
  a_vga_mem: assert property (i_p_valid && !i_p_is_io |=> o_p_claim == $past(vmem))
    else $error("memory claim wrong");
  a_vga_io: assert property (i_p_valid && vio |=> o_p_claim)
    else $error("vga io not claimed");
  c_perr: cover property (i_s_data_perr && bc[0]);
  c_fwd: cover property (!o_p_serr_oe_n && bc[1]);
  c_vga: cover property (i_p_valid && vio);
endmodule : bcd_ctrl_chk
bind bcd_ctrl bcd_ctrl_chk i_chk (
  .i_mclk           (i_mclk),
  .i_rst            (i_rst),
  .i_s_data_perr    (i_s_data_perr),
  .i_s_master       (i_s_master),
  .i_s_addr_perr    (i_s_addr_perr),
  .i_s_serr_l       (i_s_serr_l),
  .i_serr_drv_en    (i_serr_drv_en),
  .i_io_space_en    (i_io_space_en),
  .i_mem_space_en   (i_mem_space_en),
  .i_p_valid        (i_p_valid),
  .i_p_is_io        (i_p_is_io),
  .i_p_addr         (i_p_addr),
  .o_s_perr_oe_n    (o_s_perr_oe_n),
  .o_p_serr_oe_n    (o_p_serr_oe_n),
  .o_s_dpr_set      (o_s_dpr_set),
  .o_p_claim        (o_p_claim),
  .o_bridge_control (o_bridge_control)
);

/* bench/bridge_ctrl_decode_error_fwd_tb.sv */
// self-checking bench for the bridge control block
`timescale 1ns/1ps
module bridge_ctrl_decode_error_fwd_tb;
  logic i_mclk = 0, i_rst = 1, i_cfg_wr = 0, i_cfg_rd = 0, i_io_space_en = 1, seen;
  logic i_mem_space_en = 1, i_serr_drv_en = 1, i_s_data_perr = 0, i_s_master = 1;
  logic i_s_addr_perr = 0, i_p_valid = 0, i_p_is_io = 0, i_s_valid = 0, i_s_is_io = 0;
  logic i_s_serr_l, serr_on = 0, o_cfg_rvalid, o_s_perr_l_o, o_s_perr_oe_n, o_p_serr_l_o;
  logic o_p_serr_oe_n, o_s_dpr_set, o_p_claim, o_s_claim;
  logic [5:0]  i_cfg_dw_addr = 6'h0F;
  logic [3:0]  i_cfg_be_n = 4'h0;
  logic [31:0] i_cfg_wdata = 32'h0, i_io_base = 32'h0, i_io_limit = 32'h0000_FFFF;
  logic [31:0] i_p_addr = 32'h0, i_s_addr = 32'h0, o_cfg_rdata;
  logic [15:0] o_bridge_control;
  int fails = 0, compares = 0;
  always #50 i_mclk = ~i_mclk;
  bcd_ctrl i_dut (
    .i_mclk           (i_mclk),
    .i_rst            (i_rst),
    .i_cfg_wr         (i_cfg_wr),
    .i_cfg_rd         (i_cfg_rd),
    .i_cfg_dw_addr    (i_cfg_dw_addr),
    .i_cfg_be_n       (i_cfg_be_n),
    .i_cfg_wdata      (i_cfg_wdata),
    .o_cfg_rdata      (o_cfg_rdata),
    .o_cfg_rvalid     (o_cfg_rvalid),
    .i_io_space_en    (i_io_space_en),
    .i_mem_space_en   (i_mem_space_en),
    .i_serr_drv_en    (i_serr_drv_en),
    .i_io_base        (i_io_base),
    .i_io_limit       (i_io_limit),
    .i_s_data_perr    (i_s_data_perr),
    .i_s_master       (i_s_master),
    .i_s_addr_perr    (i_s_addr_perr),
    .i_s_serr_l       (i_s_serr_l),
    .o_s_perr_l_o     (o_s_perr_l_o),
    .o_s_perr_oe_n    (o_s_perr_oe_n),
    .o_p_serr_l_o     (o_p_serr_l_o),
    .o_p_serr_oe_n    (o_p_serr_oe_n),
    .o_s_dpr_set      (o_s_dpr_set),
    .i_p_valid        (i_p_valid),
    .i_p_is_io        (i_p_is_io),
    .i_p_addr         (i_p_addr),
    .o_p_claim        (o_p_claim),
    .i_s_valid        (i_s_valid),
    .i_s_is_io        (i_s_is_io),
    .i_s_addr         (i_s_addr),
    .o_s_claim        (o_s_claim),
    .o_bridge_control (o_bridge_control)
  );
  bcd_agent i_agent (.i_assert(serr_on), .o_serr_l(i_s_serr_l));
  task automatic chk(input logic [31:0] sv, ev, input string what);
    compares++;
    if (sv !== ev) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, ev, sv);
    end
  endtask : chk
  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic set_ctl(input logic [3:0] b);
    i_cfg_wr = 1;
    i_cfg_wdata = {12'h000, b, 16'h0000};
    @(negedge i_mclk);
    i_cfg_wr = 0;
    chk(o_bridge_control, {12'h000, b}, "control");
  endtask : set_ctl
  task automatic rd_chk(input logic [3:0] b);
    i_cfg_rd = 1;
    @(negedge i_mclk);
    i_cfg_rd = 0;
    chk(o_cfg_rvalid, 32'h0000_0001, "rvalid");
    chk(o_cfg_rdata, {12'h000, b, 16'h0000}, "rdata");
    // idle edge so the next read strobe is a fresh pulse
    @(negedge i_mclk);
  endtask : rd_chk
  // decode request; claim is registered, so judged one edge later
  task automatic dec(input logic s, io, input logic [31:0] a, input logic e);
    {i_p_valid, i_s_valid, i_p_is_io, i_s_is_io} = {~s, s, io, io};
    {i_p_addr, i_s_addr} = {a, a};
    @(negedge i_mclk);
    {i_p_valid, i_s_valid} = 2'h0;
    chk(s ? o_s_claim : o_p_claim, e, "claim");
    @(negedge i_mclk);
  endtask : dec
  // e is {active-low pin enable, flag strobe}
  task automatic err(input logic d, input logic [1:0] e);
    {i_s_data_perr, i_s_addr_perr} = {d, ~d};
    @(negedge i_mclk);
    {i_s_data_perr, i_s_addr_perr} = 2'h0;
    chk({d ? o_s_perr_oe_n : o_p_serr_oe_n, o_s_dpr_set}, e, "error");
    chk({o_s_perr_l_o, o_p_serr_l_o}, 32'h0000_0000, "pin data");
    @(negedge i_mclk);
  endtask : err
  // mid-run reset must bring every control bit back to zero
  task automatic rst_chk;
    i_rst = 1;
    repeat (4) @(negedge i_mclk);
    i_rst = 0;
    chk(o_bridge_control, 32'h0000_0000, "reset");
    rd_chk(4'h0);
  endtask : rst_chk
  // pin passes a synchroniser, so allow a bounded settling span
  task automatic serr(input logic e);
    serr_on = 1;
    seen = 0;
    repeat (10) @(negedge i_mclk) if (!o_p_serr_oe_n) seen = 1;
    serr_on = 0;
    repeat (6) @(negedge i_mclk);
    chk(seen, e, "forward");
  endtask : serr
  initial begin
    repeat (4) @(negedge i_mclk);
    i_rst = 0;
    rd_chk(4'h0);
    err(1, 2'h2);
    err(0, 2'h2);
    serr(0);
    set_ctl(4'h3);
    rd_chk(4'h3);
    i_cfg_dw_addr = 6'h0E;
    rd_chk(4'h0);
    i_cfg_dw_addr = 6'h0F;
    err(1, 2'h1);
    err(0, 2'h0);
    serr(1);
    dec(0, 1, 32'h0000_1100, 1);
    set_ctl(4'h4);
    dec(0, 1, 32'h0000_1100, 0);
    dec(0, 1, 32'h0000_1000, 1);
    dec(1, 1, 32'h0000_1100, 1);
    dec(1, 1, 32'h0000_1000, 0);
    {i_io_base, i_io_limit} = {32'h0000_2000, 32'h0000_2FFF};
    dec(0, 1, 32'h0000_03C0, 0);
    set_ctl(4'h8);
    dec(0, 1, 32'h0000_07B0, 1);
    dec(0, 1, 32'h0001_03C0, 0);
    dec(0, 0, 32'h000B_FFFF, 1);
    dec(0, 0, 32'h000C_0000, 0);
    dec(1, 0, 32'h000A_0000, 0);
    dec(1, 0, 32'h000C_0000, 1);
    i_mem_space_en = 0;
    dec(0, 0, 32'h000A_0000, 0);
    rst_chk();
    print_verdict();
  end
endmodule : bridge_ctrl_decode_error_fwd_tb
